// ==== core/cmpc_ctrl.sv ====
// Contract
// R1 - Standby run bit keeps comparator on in standby; clear halts it there.
// R2 - Flags and interrupt state freeze while standby runs without clock.
// R3 - Pad output enable drives the comparator output onto its pin.
// R4 - Two-bit power profile selects profile 0 to 2; code 3 reserved.
// R5 - Two-bit hysteresis field selects none, small, medium or large.
// R6 - Enable bit switches the comparator on; zero keeps it off.
// R7 - Window partner field: off, next, second next; code 3 reserved.
// R8 - Invert bit inverts output to pin and system consumers.
// R9 - Until comparator ready, output holds the initial value bit.
// R10 - Positive select routes positive pins 0 to 3; others reserved.
// R11 - Negative select routes pins 0 to 2, code 3 threshold generator.
// R12 - Threshold register resets to FF and sets level over 256.
// R13 - Window interrupt modes: above, inside, below, outside.
// R14 - Single modes: any crossing, rise above, fall below; code 1 reserved.
// R15 - Interrupt request only when enable bit and flag both set.
// R16 - Window state reports above 0, inside 1, below 2.
// R17 - Outside window mode, state bit mirrors output level.
// R18 - In window mode, state bit is one when state matches mode.
// R19 - State bit follows comparator change three clock cycles later.
// R20 - Flag sets on mode match; writing one clears, zero ignored.
// R21 - Interrupt request stays active until software clears the flag.
// R22 - Power-down sleep disables comparator and pad drive.
// R23 - Detection uses synchronised result, current versus previous sample.
// R24 - Reserved bits and offsets 3 and 4 read zero, ignore writes.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "cmpc_regs.svh"

module cmpc_ctrl
  import cmpc_pkg::*;
#(
  parameter int AW = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_raw,
  input wire logic partner_raw,
  input wire logic core_ready,
  input wire logic standby_sleep,
  input wire logic powerdown_sleep,
  output logic core_enable,
  output logic [1:0] power_profile,
  output logic [1:0] hysteresis_select,
  output logic [2:0] positive_input_select,
  output logic [2:0] negative_input_select,
  output logic [7:0] threshold_level,
  output cmpc_partner_t window_partner,
  output logic cmp_out,
  output logic out_pin_o,
  output logic out_pin_oe,
  output logic irq
);

  initial
  begin
    if (AW < 5)
      $error("cmpc_ctrl: AW must be at least 5");
  end

  cmpc_main_t main_r;
  logic [7:0] wpair_r;
  cmpc_insel_t insel_r;
  logic [7:0] thresh_r;
  logic [7:0] irqc_r;
  logic flag_r;
  logic cstate_r;
  cmpc_wstate_t wstate_r;
  logic own_s1_r;
  logic own_s2_r;
  logic par_s1_r;
  logic par_s2_r;
  logic prev_out_r;
  logic prev_match_r;
  logic cmp_out_r;
  logic [31:0] prdata_r;

  logic [2:0] idx;
  logic mapped;
  logic wr_en;
  logic rd_setup;
  logic clr_flag;
  logic win_on;
  logic out_lvl;
  cmpc_wstate_t wstate_nxt;
  logic match_nxt;
  logic trig;
  logic frozen;
  logic halted;
  logic [7:0] rd_nxt;

  // APB decode
  assign idx = paddr[4:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[AW-1:5] == '0);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      main_r <= cmpc_main_t'(`CMPC_RST_MAIN);
      wpair_r <= `CMPC_RST_WPAIR;
      insel_r <= cmpc_insel_t'(`CMPC_RST_INSEL);
      thresh_r <= `CMPC_RST_THRESH; // see R12
      irqc_r <= `CMPC_RST_IRQC;
    end
    else if (wr_en)
    begin
      case (idx)
        `CMPC_IDX_MAIN: main_r <= cmpc_main_t'(pwdata[7:0] & `CMPC_MASK_MAIN); // see R24
        `CMPC_IDX_WPAIR: wpair_r <= pwdata[7:0] & `CMPC_MASK_WPAIR;
        `CMPC_IDX_INSEL: insel_r <= cmpc_insel_t'(pwdata[7:0]);
        `CMPC_IDX_THRESH: thresh_r <= pwdata[7:0];
        `CMPC_IDX_IRQC: irqc_r <= pwdata[7:0] & `CMPC_MASK_IRQC;
        default: ;
      endcase
    end
  end

  // Read data latched in the setup phase
  always_comb
  begin
    rd_nxt = 8'h00; // see R24
    case (idx)
      `CMPC_IDX_MAIN: rd_nxt = main_r;
      `CMPC_IDX_WPAIR: rd_nxt = wpair_r;
      `CMPC_IDX_INSEL: rd_nxt = insel_r;
      `CMPC_IDX_THRESH: rd_nxt = thresh_r;
      `CMPC_IDX_IRQC: rd_nxt = irqc_r;
      `CMPC_IDX_STATE: rd_nxt = {wstate_r, 1'b0, cstate_r, 3'h0, flag_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata_r <= 32'h0000_0000;
    else if (rd_setup)
      prdata_r <= (mapped && !pwrite) ? {24'h00_0000, rd_nxt} : 32'h0000_0000;
  end

  // Analog core controls
  assign halted = powerdown_sleep || (standby_sleep && !main_r.standby_run); // see R1
  assign core_enable = main_r.enable && !halted; // see R6
  assign power_profile = main_r.power_profile; // see R4
  assign hysteresis_select = main_r.hysteresis_select; // see R5
  assign positive_input_select = insel_r.positive_input_select; // see R10
  assign negative_input_select = insel_r.negative_input_select; // see R11
  assign threshold_level = thresh_r; // see R12
  assign window_partner = cmpc_partner_t'(wpair_r[1:0]); // see R7
  assign win_on = (window_partner == CMPC_WIN_PAIR_NEXT)
    || (window_partner == CMPC_WIN_PAIR_SECOND_NEXT);

  // Two-stage synchronisers for own and partner results
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      own_s1_r <= 1'b0;
      own_s2_r <= 1'b0;
      par_s1_r <= 1'b0;
      par_s2_r <= 1'b0;
    end
    else
    begin
      own_s1_r <= cmp_raw;
      own_s2_r <= own_s1_r;
      par_s1_r <= partner_raw;
      par_s2_r <= par_s1_r;
    end
  end

  // Output level after initial value and inversion
  assign out_lvl = (main_r.enable && core_ready)
    ? (own_s2_r ^ insel_r.invert) // see R8
    : insel_r.initial_value; // see R9

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmp_out_r <= 1'b0;
    else
      cmp_out_r <= out_lvl;
  end

  assign cmp_out = cmp_out_r;
  assign out_pin_o = cmp_out_r;
  assign out_pin_oe = main_r.pad_output_enable && !halted; // see R3 see R22

  // Window state and mode match
  always_comb
  begin
    if (own_s2_r)
      wstate_nxt = CMPC_WS_ABOVE; // see R16
    else if (par_s2_r)
      wstate_nxt = CMPC_WS_INSIDE;
    else
      wstate_nxt = CMPC_WS_BELOW;
    case (irqc_r[5:4])
      2'h0: match_nxt = (wstate_nxt == CMPC_WS_ABOVE); // see R13
      2'h1: match_nxt = (wstate_nxt == CMPC_WS_INSIDE);
      2'h2: match_nxt = (wstate_nxt == CMPC_WS_BELOW);
      default: match_nxt = (wstate_nxt != CMPC_WS_INSIDE); // see R18
    endcase
  end

  // Trigger from current versus previous sample
  always_comb
  begin
    trig = 1'b0;
    if (win_on)
      trig = match_nxt && !prev_match_r; // see R23
    else
    begin
      case (irqc_r[5:4])
        2'h0: trig = out_lvl != prev_out_r; // see R14
        2'h2: trig = out_lvl && !prev_out_r;
        2'h3: trig = !out_lvl && prev_out_r;
        default: trig = 1'b0;
      endcase
    end
  end

  assign frozen = standby_sleep || powerdown_sleep; // see R2
  assign clr_flag = wr_en && (idx == `CMPC_IDX_STATE) && pwdata[`CMPC_BIT_FLAG];

  // Status: samples, state bit and sticky flag
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev_out_r <= 1'b0;
      prev_match_r <= 1'b0;
      cstate_r <= 1'b0;
      wstate_r <= CMPC_WS_ABOVE;
    end
    else if (!frozen)
    begin
      prev_out_r <= out_lvl;
      prev_match_r <= match_nxt;
      cstate_r <= win_on ? match_nxt : out_lvl; // see R17 see R19
      wstate_r <= win_on ? wstate_nxt : CMPC_WS_ABOVE; // see R16
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flag_r <= 1'b0;
    else if (!frozen && trig)
      flag_r <= 1'b1; // see R20
    else if (clr_flag)
      flag_r <= 1'b0; // see R21
  end

  assign irq = irqc_r[`CMPC_BIT_IRQEN] && flag_r; // see R15

  // Assertions
  property p_irq_gate;
    @(posedge clk) disable iff (!rst_n)
    irq == (irqc_r[0] && flag_r);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable and flag"); // see R15

  property p_flag_sticky;
    @(posedge clk) disable iff (!rst_n)
    flag_r && !clr_flag |=> flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped uncleared"); // see R21

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
    trig && !frozen && clr_flag |=> flag_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear"); // see R20

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    clr_flag && !(trig && !frozen) |=> !flag_r;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared"); // see R20

  property p_frozen;
    @(posedge clk) disable iff (!rst_n)
    frozen && !clr_flag |=> $stable(flag_r) && $stable(cstate_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("status changed while frozen"); // see R2

  property p_three_cycles;
    @(posedge clk) disable iff (!rst_n)
    !win_on && !insel_r.invert && main_r.enable && core_ready && !frozen
      |=> cstate_r == $past(cmp_raw, 3);
  endproperty
  a_three_cycles: assert property (p_three_cycles) else $error("state bit delay wrong"); // see R19

  property p_initial_value;
    @(posedge clk) disable iff (!rst_n)
    !core_ready |=> cmp_out == $past(insel_r.initial_value);
  endproperty
  a_initial_value: assert property (p_initial_value) else $error("initial value not held"); // see R9

  property p_powerdown;
    @(posedge clk) disable iff (!rst_n)
    powerdown_sleep |-> !core_enable && !out_pin_oe;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("active in power-down"); // see R22

  property p_standby;
    @(posedge clk) disable iff (!rst_n)
    standby_sleep && !powerdown_sleep && main_r.enable |-> core_enable == main_r.standby_run;
  endproperty
  a_standby: assert property (p_standby) else $error("standby run ignored"); // see R1

  property p_reserved_read;
    @(posedge clk) disable iff (!rst_n)
    rd_setup && mapped && !pwrite && (idx == 3'h3 || idx == 3'h4) |=> prdata == 32'h0;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved reads nonzero"); // see R24

  property p_rise_sets;
    @(posedge clk) disable iff (!rst_n)
    !win_on && irqc_r[5:4] == 2'h2 && !frozen && out_lvl && !prev_out_r |=> flag_r;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising output missed"); // see R14

  property p_window_inside;
    @(posedge clk) disable iff (!rst_n)
    win_on && !frozen && !own_s2_r && par_s2_r |=> wstate_r == CMPC_WS_INSIDE;
  endproperty
  a_window_inside: assert property (p_window_inside) else $error("inside state missed"); // see R16

endmodule // cmpc_ctrl

// ==== core/cmpc_regs.svh ====
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH

// Register indices, byte address is four times the index
`define CMPC_IDX_MAIN 3'h0
`define CMPC_IDX_WPAIR 3'h1
`define CMPC_IDX_INSEL 3'h2
`define CMPC_IDX_THRESH 3'h5
`define CMPC_IDX_IRQC 3'h6
`define CMPC_IDX_STATE 3'h7

// Reset values
`define CMPC_RST_MAIN 8'h00
`define CMPC_RST_WPAIR 8'h00
`define CMPC_RST_INSEL 8'h00
`define CMPC_RST_THRESH 8'hFF
`define CMPC_RST_IRQC 8'h00

// Writable bits
`define CMPC_MASK_MAIN 8'hDF
`define CMPC_MASK_WPAIR 8'h03
`define CMPC_MASK_IRQC 8'h31

// Field positions
`define CMPC_BIT_ENABLE 0
`define CMPC_BIT_PADOE 6
`define CMPC_BIT_STBYRUN 7
`define CMPC_BIT_IRQEN 0
`define CMPC_BIT_FLAG 0
`define CMPC_BIT_CSTATE 4

// Delay from raw result to state bit in clock cycles
`define CMPC_SYNC_CYCLES 3

`endif

// ==== core/cmpc_pkg.sv ====
package cmpc_pkg;

  typedef enum logic [1:0] {
    CMPC_WIN_OFF,
    CMPC_WIN_PAIR_NEXT,
    CMPC_WIN_PAIR_SECOND_NEXT,
    CMPC_WIN_RSVD
  } cmpc_partner_t;

  typedef enum logic [1:0] {
    CMPC_WS_ABOVE,
    CMPC_WS_INSIDE,
    CMPC_WS_BELOW,
    CMPC_WS_RSVD
  } cmpc_wstate_t;

  typedef struct packed {
    logic standby_run;
    logic pad_output_enable;
    logic rsvd;
    logic [1:0] power_profile;
    logic [1:0] hysteresis_select;
    logic enable;
  } cmpc_main_t;

  typedef struct packed {
    logic invert;
    logic initial_value;
    logic [2:0] positive_input_select;
    logic [2:0] negative_input_select;
  } cmpc_insel_t;

endpackage

// ==== tb/cmpc_core_model.sv ====
`timescale 1ns/1ps

module cmpc_core_model
#(
  parameter int START = 8
)
(
  input wire logic clk,
  input wire logic core_enable,
  input wire logic own_level,
  input wire logic partner_level,
  output logic cmp_raw = 1'h0,
  output logic partner_raw = 1'h0,
  output logic core_ready = 1'h0
);
  int cnt = 0;

  // Start-up delay after switch-on, off whenever not enabled
  always @(posedge clk)
  begin
    if (!core_enable)
    begin
      cnt <= 0;
      core_ready <= 1'h0;
    end
    else if (cnt < START)
      cnt <= cnt + 1;
    else
      core_ready <= 1'h1;
  end

  // Result toggles freely until ready
  always @(posedge clk)
    cmp_raw <= core_ready ? own_level : ~cmp_raw;

  always @(posedge clk)
    partner_raw <= partner_level;
endmodule // cmpc_core_model

// ==== tb/test_comparator_control_regs.sv ====
`timescale 1ns/1ps

module test_comparator_control_regs
  import cmpc_pkg::*;
();
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, cmp_raw, partner_raw, core_ready;
  logic standby_sleep, powerdown_sleep, core_enable, cmp_out, out_pin_o, out_pin_oe, irq;
  logic own_level, partner_level, err;
  logic [1:0] power_profile, hysteresis_select;
  logic [2:0] positive_input_select, negative_input_select;
  logic [7:0] paddr, threshold_level;
  logic [31:0] pwdata, prdata, rd;
  cmpc_partner_t window_partner;
  int errors, n_compared, n;
  int cycles = 0;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
  logic [7:0] msk_tab [8] = '{8'hDF, 8'h03, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h31, 8'h00};
  logic [1:0] md_tab [5] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
  logic [4:0] ex_tab = 5'h09;

  cmpc_ctrl #(.AW(8)) u_cmpc_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .partner_raw(partner_raw), .core_ready(core_ready),
    .standby_sleep(standby_sleep), .powerdown_sleep(powerdown_sleep),
    .core_enable(core_enable), .power_profile(power_profile),
    .hysteresis_select(hysteresis_select), .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select), .threshold_level(threshold_level),
    .window_partner(window_partner), .cmp_out(cmp_out), .out_pin_o(out_pin_o),
    .out_pin_oe(out_pin_oe), .irq(irq));

  cmpc_core_model #(.START(8)) u_cmpc_core_model (.clk(clk), .core_enable(core_enable),
    .own_level(own_level), .partner_level(partner_level), .cmp_raw(cmp_raw),
    .partner_raw(partner_raw), .core_ready(core_ready));

  task test_done;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, holds the request until pready is sampled high
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge clk);
  endtask

  task wr(input int i, input logic [7:0] d);
    xfer(8'(i * 4), 1'h1, {24'h0, d});
  endtask

  task rdr(input int i);
    xfer(8'(i * 4), 1'h0, 32'h0);
  endtask

  task set_lv(input logic o, input logic p);
    @(posedge clk);
    own_level <= o;
    partner_level <= p;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  task sleep_set(input logic s, input logic p);
    @(posedge clk);
    standby_sleep <= s;
    powerdown_sleep <= p;
    @(negedge clk);
  endtask

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, standby_sleep, powerdown_sleep} = 6'h00;
    {own_level, partner_level} = 2'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    // Reset values, access masks, reserved places
    for (int i = 0; i < 8; i++)
    begin
      rdr(i);
      chk("reset value", {24'h0, rst_tab[i]}, rd);
    end
    for (int i = 0; i < 7; i++)
    begin
      wr(i, 8'hFF);
      rdr(i);
      chk("masked readback", {24'h0, msk_tab[i]}, rd);
      wr(i, 8'h00);
    end
    xfer(8'h20, 1'h0, 32'h0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    // Every power, hysteresis, partner and input select code reaches its port
    for (int j = 0; j < 8; j++)
    begin
      wr(0, 8'((j % 4) << 3 | (3 - j % 4) << 1));
      chk("power profile", j % 4, power_profile);
      chk("hysteresis", 3 - j % 4, hysteresis_select);
      wr(1, 8'(j % 4));
      chk("window partner", j % 4, window_partner);
      wr(2, 8'(j << 3 | (7 - j)));
      chk("positive select", j, positive_input_select);
      chk("negative select", 7 - j, negative_input_select);
    end
    wr(5, 8'h5A);
    chk("threshold", 8'h5A, threshold_level);
    wr(0, 8'h00);
    wr(1, 8'h00);
    // Switch-on with initial value high and result low
    wr(2, 8'h40);
    wr(0, 8'h41);
    chk("core enable", 1, core_enable);
    chk("initial output", 1, cmp_out);
    chk("pad enable", 1, out_pin_oe);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("output low", 0, cmp_out);
    chk("pin level", 0, out_pin_o);
    @(posedge clk);
    own_level <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end
    while (cmp_out !== 1'h1 && n < 10);
    chk("sync delay", 4, n);
    rdr(7);
    chk("state mirror", 1, rd[4]);
    wr(2, 8'hC0);
    repeat (5) @(negedge clk);
    chk("inverted output", 0, cmp_out);
    wr(2, 8'h00);
    // Flag and request on any crossing
    wr(6, 8'h01);
    wr(7, 8'h01);
    chk("irq idle", 0, irq);
    set_lv(1'h0, 1'h0);
    rdr(7);
    chk("flag any crossing", 1, rd[0]);
    repeat (10) @(negedge clk);
    chk("irq held", 1, irq);
    wr(7, 8'h00);
    rdr(7);
    chk("flag write zero", 1, rd[0]);
    wr(6, 8'h00);
    chk("irq masked", 0, irq);
    wr(6, 8'h01);
    chk("irq unmasked", 1, irq);
    wr(7, 8'h01);
    rdr(7);
    chk("flag cleared", 0, rd[0]);
    chk("irq cleared", 0, irq);
    for (int i = 0; i < 5; i++)
    begin
      wr(6, {2'h0, md_tab[i], 4'h1});
      wr(7, 8'h01);
      set_lv(!i[0], 1'h0);
      rdr(7);
      chk("edge mode flag", ex_tab[i], rd[0]);
    end
    // Event and clear in one cycle, set wins
    wr(6, 8'h01);
    wr(7, 8'h01);
    @(posedge clk);
    own_level <= 1'h0;
    @(posedge clk);
    wr(7, 8'h01);
    rdr(7);
    chk("set beats clear", 1, rd[0]);
    // Window pairing, mode inside then outside
    wr(1, 8'h01);
    wr(6, 8'h11);
    for (int i = 0; i < 3; i++)
    begin
      wr(7, 8'h01);
      set_lv(i == 0, i < 2);
      rdr(7);
      chk("window state", i, rd[7:6]);
      chk("window match", i == 1, rd[4]);
      chk("window flag", i == 1, rd[0]);
    end
    wr(6, 8'h31);
    rdr(7);
    chk("outside match", 1, rd[4]);
    wr(1, 8'h00);
    // Sleep modes
    wr(0, 8'h41);
    sleep_set(1'h1, 1'h0);
    chk("standby halt", 0, core_enable);
    chk("standby pad", 0, out_pin_oe);
    wr(0, 8'hC1);
    chk("standby run", 1, core_enable);
    chk("standby run pad", 1, out_pin_oe);
    wr(6, 8'h01);
    wr(7, 8'h01);
    set_lv(1'h1, 1'h0);
    rdr(7);
    chk("frozen status", 0, rd[4:0]);
    sleep_set(1'h0, 1'h0);
    repeat (6) @(negedge clk);
    rdr(7);
    chk("state after wake", 1, rd[4]);
    sleep_set(1'h0, 1'h1);
    chk("powerdown core", 0, core_enable);
    chk("powerdown pad", 0, out_pin_oe);
    sleep_set(1'h0, 1'h0);
    test_done();
  end
endmodule // test_comparator_control_regs
